// ==== include/odc_pkg.sv ====
// constants and types for the operand field decoder
package odc_pkg;

  // ----------------------------------------
  // widths and field positions
  // ----------------------------------------
  localparam int ODC_XLEN   = 32;
  localparam int ODC_DST_HI = 11;
  localparam int ODC_DST_LO = 8;
  localparam int ODC_SRC_HI = 7;
  localparam int ODC_SRC_LO = 4;
  localparam int ODC_D4_HI  = 3;
  localparam int ODC_D8_HI  = 7;
  localparam int ODC_D12_HI = 11;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0] ODC_WORD_RST = 32'h0000_0000;
  localparam logic [3:0]  ODC_REG_RST  = 4'h0;
  localparam logic [3:0]  ODC_REG0     = 4'h0;

  // ----------------------------------------
  // opcode patterns
  // ----------------------------------------
  localparam logic [3:0] OP_GRP0    = 4'h0;
  localparam logic [3:0] OP_GRP4    = 4'h4;
  localparam logic [3:0] OP_GRP8    = 4'h8;
  localparam logic [3:0] OP_GRPC    = 4'hC;
  localparam logic [3:0] OP_NMD_ST  = 4'h1;
  localparam logic [3:0] OP_NMD_LD  = 4'h5;
  localparam logic [3:0] OP_ADD_I   = 4'h7;
  localparam logic [3:0] OP_XFER_I  = 4'hE;
  localparam logic [3:0] OP_PCLD_W  = 4'h9;
  localparam logic [3:0] OP_PCLD_L  = 4'hD;
  localparam logic [3:0] OP_JUMP    = 4'hA;
  localparam logic [3:0] OP_JUMP_SB = 4'hB;
  localparam logic [3:0] OP_MACW_LO = 4'hF;
  localparam logic [7:0] OP_EQCMP_I = 8'h88;
  localparam logic [7:0] OP_TRAP    = 8'hC3;
  localparam logic [7:0] OP_ADRCALC = 8'hC7;
  localparam logic [7:0] OP_JREL_LO = 8'h23;
  localparam logic [7:0] OP_JRSB_LO = 8'h03;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [3:0] {
    FMT_ZERO, FMT_N, FMT_M, FMT_NM, FMT_MD, FMT_ND4,
    FMT_NMD, FMT_D, FMT_D12, FMT_ND8, FMT_I, FMT_NI
  } odc_fmt_t;

  typedef enum logic [1:0] {LEN4, LEN8, LEN12} odc_len_t;
  typedef enum logic [1:0] {SC1, SC2, SC4} odc_scale_t;
  typedef enum logic [2:0] {EA_NONE, EA_PC_DISP, EA_PC_REG, EA_GB_DISP, EA_GB_REG0} odc_ea_t;

endpackage

// ==== testbench/odc_fetch_model.sv ====
// fetch and register-file model feeding the operand field decoder
`timescale 1ns/1ps
module odc_fetch_model #(
  parameter logic [31:0] GBASE_VAL = 32'h0200_0000
) (
  input  wire logic [15:0] instr_word,
  output logic      [31:0] gr_data,
  output logic      [31:0] reg0_data,
  output logic      [31:0] gbase_data
);
  // ----------------------------------------
  // register file contents
  // ----------------------------------------
  // each register holds its own pattern, so a wrong field pick shows up
  assign gr_data  = 32'h0100_0000 + {24'h0, instr_word[11:8], 4'h0};
  assign reg0_data  = 32'h0100_0000;
  assign gbase_data = GBASE_VAL;
endmodule

// ==== testbench/operand_field_decoder_test.sv ====
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
module operand_field_decoder_test;
  import odc_pkg::*;
  localparam logic [31:0] PCV = 32'h0000_4000;
  localparam logic [31:0] GBV = 32'h0200_0000;
  logic            core_clk;
  logic            resetn;
  logic            instr_valid;
  logic     [15:0] instr_word;
  logic     [31:0] pc;
  logic     [31:0] gr_data;
  logic     [31:0] reg0_data;
  logic     [31:0] gbase_data;
  logic            dec_valid;
  odc_fmt_t        dec_fmt;
  logic      [3:0] dst_reg;
  logic      [3:0] src_reg;
  logic            dst_used;
  logic            dst_pre_dec;
  logic            dst_post_inc;
  logic            src_used;
  logic            src_post_inc;
  logic     [31:0] disp_val;
  logic            disp_used;
  logic     [31:0] imm_val;
  logic            imm_used;
  logic     [31:0] eff_addr;
  logic            ea_used;
  logic            mac_target;
  int              err_count;
  int              total_checks;
  int              cycles;

  odc_fetch_model #(.GBASE_VAL(GBV)) odc_fetch_model_inst (
    .instr_word(instr_word), .gr_data(gr_data), .reg0_data(reg0_data), .gbase_data(gbase_data));

  odc_decoder odc_decoder_inst (
    .core_clk(core_clk), .resetn(resetn), .instr_valid(instr_valid), .instr_word(instr_word),
    .pc(pc), .gr_data(gr_data), .reg0_data(reg0_data), .gbase_data(gbase_data), .dec_valid(dec_valid),
    .dec_fmt(dec_fmt), .dst_reg(dst_reg), .dst_used(dst_used), .dst_pre_dec(dst_pre_dec),
    .dst_post_inc(dst_post_inc), .src_reg(src_reg), .src_used(src_used),
    .src_post_inc(src_post_inc), .disp_val(disp_val), .disp_used(disp_used),
    .imm_val(imm_val), .imm_used(imm_used), .eff_addr(eff_addr), .ea_used(ea_used),
    .mac_target(mac_target));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // compare, drive and closing tasks
  // ----------------------------------------
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // word goes in at a falling edge, its decode is settled one falling edge later
  task automatic go(input logic [15:0] w);
    @(negedge core_clk);
    instr_valid = 1'b1;
    instr_word  = w;
    @(negedge core_clk);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_jump;
    go(16'hA005);
    chk_v(32'(dec_fmt), 32'(FMT_D12));
    chk_v(disp_val, 32'h0000_000A);
    chk_v(eff_addr, PCV + 32'hA);
    chk_b(dst_used | src_used | imm_used, 1'b0);
    go(16'hAFFF);
    chk_v(disp_val, 32'hFFFF_FFFE);
    chk_v(eff_addr, PCV - 32'h2);
    $display("test jump done");
  endtask

  task automatic t_branch;
    go(16'h8B80);
    chk_v(32'(dec_fmt), 32'(FMT_D));
    chk_v(disp_val, 32'hFFFF_FF00);
    chk_v(eff_addr, PCV - 32'h100);
    go(16'h0523);
    chk_v({28'h0, src_reg}, 32'h5);
    chk_v(eff_addr, PCV + 32'h0100_0050);
    go(16'hC705);
    chk_v(eff_addr, PCV + 32'h14);
    $display("test branch done");
  endtask

  task automatic t_imm;
    // 0x80 tells zero from sign extension apart
    for (int i = 0; i < 4; i++) begin
      go({8'hC8 + 8'(i), 8'h80});
      chk_v(imm_val, 32'h0000_0080);
    end
    go(16'hE380);
    chk_v(imm_val, 32'hFFFF_FF80);
    chk_v({28'h0, dst_reg}, 32'h3);
    go(16'h7380);
    chk_v(imm_val, 32'hFFFF_FF80);
    go(16'h8880);
    chk_v(imm_val, 32'hFFFF_FF80);
    go(16'hC310);
    chk_v(imm_val, 32'h0000_0040);
    chk_b(ea_used, 1'b0);
    go(16'hC3FF);
    chk_v(imm_val, 32'h0000_03FC);
    chk_b(imm_used, 1'b1);
    $display("test immediate done");
  endtask

  task automatic t_gbr;
    for (int k = 0; k < 3; k++) begin
      go({8'hC0 + 8'(k), 8'h80});
      chk_v(disp_val, 32'h80 << k);
      chk_v(eff_addr, GBV + (32'h80 << k));
    end
    // byte logic at base plus register zero, register zero holds 0x0100_0000
    go(16'hCC12);
    chk_v(eff_addr, GBV + 32'h0100_0000);
    chk_v(imm_val, 32'h0000_0012);
    chk_b(ea_used, 1'b1);
    $display("test global base done");
  endtask

  task automatic t_fmt;
    go(16'h0009);
    chk_v(32'(dec_fmt), 32'(FMT_ZERO));
    chk_b(dst_used | src_used | disp_used | imm_used, 1'b0);
    go(16'h4302);
    chk_v({28'h0, dst_reg}, 32'h3);
    chk_b(dst_pre_dec, 1'b1);
    go(16'h4507);
    chk_v({28'h0, src_reg}, 32'h5);
    chk_b(src_post_inc, 1'b1);
    go(16'h3A5C);
    chk_v({24'h0, dst_reg, src_reg}, 32'hA5);
    go(16'h4A5F);
    chk_b(mac_target & dst_post_inc & src_post_inc, 1'b1);
    go(16'h8573);
    chk_v({24'h0, dst_reg, src_reg}, 32'h07);
    chk_v(disp_val, 32'h6);
    go(16'h8073);
    chk_v({24'h0, dst_reg, src_reg}, 32'h70);
    chk_v(disp_val, 32'h3);
    go(16'h1A53);
    chk_v({24'h0, dst_reg, src_reg}, 32'hA5);
    chk_v(disp_val, 32'hC);
    go(16'h9A80);
    chk_v({28'h0, dst_reg}, 32'hA);
    chk_v(eff_addr, PCV + 32'h100);
    $display("test formats done");
  endtask

  // words follow each other with no gap, then valid drops
  task automatic t_stream;
    @(negedge core_clk);
    instr_word = 16'hA005;
    @(negedge core_clk);
    instr_word = 16'hC310;
    chk_v(eff_addr, PCV + 32'hA);
    @(negedge core_clk);
    instr_valid = 1'b0;
    chk_v(imm_val, 32'h40);
    @(negedge core_clk);
    chk_b(dec_valid, 1'b0);
    $display("test stream done");
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      summarize();
    end
  end

  initial begin
    resetn      = 1'b0;
    instr_valid = 1'b1;
    instr_word  = 16'hA005;
    pc          = PCV;
    repeat (5) @(negedge core_clk);
    chk_b(dec_valid, 1'b0);
    chk_v(32'(dec_fmt), 32'(FMT_ZERO));
    resetn = 1'b1;
    t_jump();
    t_branch();
    t_imm();
    t_gbr();
    t_fmt();
    t_stream();
    summarize();
  end
endmodule

// ==== verilog/odc_decoder.sv ====
// operand field decoder for the 16-bit instruction word
`timescale 1ns/1ps
// Operation
// - short pc displacement: sign-extend, double, add
// - long pc displacement: sign-extend, double, add
// - register pc mode: pc plus register
// - logic and test immediates zero-extended
// - transfer, add, compare immediates sign-extended
// - trap immediate zero-extended times four
// - field meaning follows the opcode
// - zero format: whole word is opcode
// - n format: bits 11-8 destination
// - m format: bits 11-8 source
// - nm format: destination 11-8, source 7-4
// - word mac: both pointers post-increment
// - md format: base 7-4, disp 3-0
// - nd4 format: base 7-4, disp 3-0
// - nmd format: dst, src, 4-bit disp
// - d format: bits 7-0 displacement
// - d12 format: 12-bit jump displacement
// - nd8 format: dst 11-8, disp 7-0
// - global base displacement zero-extended, sized
module odc_decoder
  import odc_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic                   instr_valid,
  input  wire logic [15:0]            instr_word,
  input  wire logic [31:0]            pc,
  input  wire logic [31:0]            gr_data,
  input  wire logic [31:0]            reg0_data,
  input  wire logic [31:0]            gbase_data,
  output logic                        dec_valid,
  output odc_pkg::odc_fmt_t           dec_fmt,
  output logic [3:0]                  dst_reg,
  output logic                        dst_used,
  output logic                        dst_pre_dec,
  output logic                        dst_post_inc,
  output logic [3:0]                  src_reg,
  output logic                        src_used,
  output logic                        src_post_inc,
  output logic [31:0]                 disp_val,
  output logic                        disp_used,
  output logic [31:0]                 imm_val,
  output logic                        imm_used,
  output logic [31:0]                 eff_addr,
  output logic                        ea_used,
  output logic                        mac_target
);

  // ----------------------------------------
  // opcode classification
  // ----------------------------------------
  logic [3:0] op_hi;
  logic [7:0] op_hb;
  logic [3:0] op_lo;
  logic [3:0] fld_n;
  logic [3:0] fld_m;
  logic       is_zero;
  logic       is_jump;
  logic       is_cbr;
  logic       is_cmpi;
  logic       is_address_compute_op;
  logic       is_gb_xfer;
  logic       is_trap;
  logic       is_logic_i;
  logic       is_logic_b;
  logic       is_md;
  logic       is_nd4;
  logic       is_nmd;
  logic       is_nd8;
  logic       is_ni;
  logic       is_jrel;
  logic       is_mac;
  logic       is_ctl_ld;
  logic       is_ctl_st;
  logic       is_m;
  logic       is_nm;

  assign op_hi = instr_word[15:12];
  assign op_hb = instr_word[15:8];
  assign op_lo = instr_word[3:0];
  assign fld_n = instr_word[ODC_DST_HI:ODC_DST_LO];
  assign fld_m = instr_word[ODC_SRC_HI:ODC_SRC_LO];

  assign is_zero    = (op_hi == OP_GRP0) && (fld_n == 4'h0) &&
                      ((op_lo == 4'h8) || (op_lo == 4'hB) || ((op_lo == 4'h9) && !instr_word[5]));
  assign is_jump    = (op_hi == OP_JUMP) || (op_hi == OP_JUMP_SB);
  assign is_cbr     = (op_hi == OP_GRP8) && fld_n[3] && fld_n[0];
  assign is_cmpi    = (op_hb == OP_EQCMP_I);
  assign is_address_compute_op    = (op_hb == OP_ADRCALC);
  assign is_gb_xfer = (op_hi == OP_GRPC) && !fld_n[3] && (fld_n[1:0] != 2'b11);
  assign is_trap    = (op_hb == OP_TRAP);
  assign is_logic_i = (op_hi == OP_GRPC) && (fld_n[3:2] == 2'b10);
  assign is_logic_b = (op_hi == OP_GRPC) && (fld_n[3:2] == 2'b11);
  assign is_md      = (op_hi == OP_GRP8) && (fld_n[3:1] == 3'b010);
  assign is_nd4     = (op_hi == OP_GRP8) && (fld_n[3:1] == 3'b000);
  assign is_nmd     = (op_hi == OP_NMD_ST) || (op_hi == OP_NMD_LD);
  assign is_nd8     = (op_hi == OP_PCLD_W) || (op_hi == OP_PCLD_L);
  assign is_ni      = (op_hi == OP_ADD_I) || (op_hi == OP_XFER_I);
  assign is_jrel    = (op_hi == OP_GRP0) &&
                      ((instr_word[7:0] == OP_JREL_LO) || (instr_word[7:0] == OP_JRSB_LO));
  assign is_mac     = (op_hi == OP_GRP4) && (op_lo == OP_MACW_LO);
  assign is_ctl_ld  = (op_hi == OP_GRP4) && (op_lo[3:1] == 3'b011);
  assign is_ctl_st  = (op_hi == OP_GRP4) && (op_lo[3:1] == 3'b001);
  assign is_m       = is_jrel || is_ctl_ld ||
                      ((op_hi == OP_GRP4) && ((op_lo == 4'hA) || (op_lo == 4'hB) || (op_lo == 4'hE)));
  assign is_nm      = (op_hi == 4'h2) || (op_hi == 4'h3) || (op_hi == 4'h6) || is_mac ||
                      ((op_hi == OP_GRP4) && (op_lo == 4'hC)) ||
                      ((op_hi == OP_GRP0) && op_lo[2]);

  // ----------------------------------------
  // format selection
  // ----------------------------------------
  odc_fmt_t fmt_w;

  // priority matters: wide groups share opcode nibbles with narrow ones
  assign fmt_w = is_zero                        ? FMT_ZERO :
                 is_jump                        ? FMT_D12  :
                 is_ni                          ? FMT_NI   :
                 is_nd8                         ? FMT_ND8  :
                 is_nmd                         ? FMT_NMD  :
                 (is_cbr || is_address_compute_op || is_gb_xfer) ? FMT_D :
                 (is_trap || is_logic_i || is_logic_b || is_cmpi) ? FMT_I :
                 is_md                          ? FMT_MD   :
                 is_nd4                         ? FMT_ND4  :
                 is_m                           ? FMT_M    :
                 is_nm                          ? FMT_NM   :
                 ((op_hi == OP_GRP0) || (op_hi == OP_GRP4)) ? FMT_N : FMT_ZERO;

  // ----------------------------------------
  // access size and scaling choices
  // ----------------------------------------
  odc_scale_t gb_scale;
  odc_scale_t small_scale;
  odc_scale_t pcld_scale;

  assign gb_scale    = odc_scale_t'(instr_word[9:8]);
  assign small_scale = instr_word[8] ? SC2 : SC1;
  assign pcld_scale  = (op_hi == OP_PCLD_L) ? SC4 : SC2;

  // ----------------------------------------
  // per-format field routing
  // ----------------------------------------
  logic [3:0] next_dst;
  logic       next_dst_used;
  logic [3:0] next_src;
  logic       next_src_used;
  logic       next_disp_used;
  logic       next_imm_used;
  odc_len_t   disp_len;
  logic       disp_sign;
  odc_scale_t disp_scale;
  logic       imm_sign;
  odc_scale_t imm_scale;
  odc_ea_t    ea_sel;

  always_comb begin
    next_dst       = ODC_REG_RST;
    next_dst_used  = 1'b0;
    next_src       = ODC_REG_RST;
    next_src_used  = 1'b0;
    next_disp_used = 1'b0;
    next_imm_used  = 1'b0;
    disp_len       = LEN4;
    disp_sign      = 1'b0;
    disp_scale     = SC1;
    imm_sign       = 1'b0;
    imm_scale      = SC1;
    ea_sel         = EA_NONE;
    unique case (fmt_w)
      FMT_ZERO: begin
      end
      FMT_N: begin
        next_dst      = fld_n;
        next_dst_used = 1'b1;
      end
      FMT_M: begin
        next_src      = fld_n;
        next_src_used = 1'b1;
        if (is_jrel) begin
          ea_sel = EA_PC_REG;
        end
      end
      FMT_NM: begin
        next_dst      = fld_n;
        next_dst_used = 1'b1;
        next_src      = fld_m;
        next_src_used = 1'b1;
      end
      // base plus disp into register zero
      FMT_MD: begin
        next_dst       = ODC_REG0;
        next_dst_used  = 1'b1;
        next_src       = fld_m;
        next_src_used  = 1'b1;
        next_disp_used = 1'b1;
        disp_scale     = small_scale;
      end
      // register zero stored at base plus disp
      FMT_ND4: begin
        next_dst       = fld_m;
        next_dst_used  = 1'b1;
        next_src       = ODC_REG0;
        next_src_used  = 1'b1;
        next_disp_used = 1'b1;
        disp_scale     = small_scale;
      end
      FMT_NMD: begin
        next_dst       = fld_n;
        next_dst_used  = 1'b1;
        next_src       = fld_m;
        next_src_used  = 1'b1;
        next_disp_used = 1'b1;
        disp_scale     = SC4;
      end
      FMT_D: begin
        next_disp_used = 1'b1;
        disp_len       = LEN8;
        if (is_cbr) begin
          disp_sign  = 1'b1;
          disp_scale = SC2;
          ea_sel     = EA_PC_DISP;
        end else if (is_address_compute_op) begin
          next_dst      = ODC_REG0;
          next_dst_used = 1'b1;
          disp_scale    = SC4;
          ea_sel        = EA_PC_DISP;
        end else begin
          disp_scale    = gb_scale;
          ea_sel        = EA_GB_DISP;
          next_dst      = ODC_REG0;
          next_src      = ODC_REG0;
          next_dst_used = instr_word[10];
          next_src_used = !instr_word[10];
        end
      end
      FMT_D12: begin
        next_disp_used = 1'b1;
        disp_len       = LEN12;
        disp_sign      = 1'b1;
        disp_scale     = SC2;
        ea_sel         = EA_PC_DISP;
      end
      FMT_ND8: begin
        next_dst       = fld_n;
        next_dst_used  = 1'b1;
        next_disp_used = 1'b1;
        disp_len       = LEN8;
        disp_scale     = pcld_scale;
        ea_sel         = EA_PC_DISP;
      end
      FMT_I: begin
        next_imm_used = 1'b1;
        if (is_trap) begin
          imm_scale = SC4;
        end else if (is_cmpi) begin
          imm_sign      = 1'b1;
          next_src      = ODC_REG0;
          next_src_used = 1'b1;
        end else if (is_logic_b) begin
          ea_sel = EA_GB_REG0;
        end else begin
          next_dst      = ODC_REG0;
          next_dst_used = 1'b1;
        end
      end
      FMT_NI: begin
        next_imm_used = 1'b1;
        imm_sign      = 1'b1;
        next_dst      = fld_n;
        next_dst_used = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // extension and address arithmetic
  // ----------------------------------------
  logic [31:0] disp_w;
  logic [31:0] imm_w;
  logic [31:0] next_ea;

  odc_ext u_disp_ext (
    .field   (instr_word[ODC_D12_HI:0]),
    .len     (disp_len),
    .sign_en (disp_sign),
    .scale   (disp_scale),
    .value   (disp_w)
  );

  odc_ext u_imm_ext (
    .field   ({4'h0, instr_word[ODC_D8_HI:0]}),
    .len     (LEN8),
    .sign_en (imm_sign),
    .scale   (imm_scale),
    .value   (imm_w)
  );

  // gr_data is the register named by bits 11-8 of this same word
  assign next_ea = (ea_sel == EA_PC_DISP) ? pc + disp_w :
                   (ea_sel == EA_PC_REG)  ? pc + gr_data :
                   (ea_sel == EA_GB_DISP) ? gbase_data + disp_w :
                   (ea_sel == EA_GB_REG0) ? gbase_data + reg0_data : ODC_WORD_RST;

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  // one capture edge, no stall
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dec_valid <= 1'b0;
      dec_fmt   <= FMT_ZERO;
      dst_reg   <= ODC_REG_RST;
      dst_used  <= 1'b0;
      src_reg   <= ODC_REG_RST;
      src_used  <= 1'b0;
      disp_val  <= ODC_WORD_RST;
      disp_used <= 1'b0;
    end else begin
      dec_valid <= instr_valid;
      dec_fmt   <= fmt_w;
      dst_reg   <= next_dst;
      dst_used  <= next_dst_used;
      src_reg   <= next_src;
      src_used  <= next_src_used;
      disp_val  <= next_disp_used ? disp_w : ODC_WORD_RST;
      disp_used <= next_disp_used;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      imm_val      <= ODC_WORD_RST;
      imm_used     <= 1'b0;
      eff_addr     <= ODC_WORD_RST;
      ea_used      <= 1'b0;
      dst_pre_dec  <= 1'b0;
      dst_post_inc <= 1'b0;
      src_post_inc <= 1'b0;
      mac_target   <= 1'b0;
    end else begin
      imm_val      <= next_imm_used ? imm_w : ODC_WORD_RST;
      imm_used     <= next_imm_used;
      eff_addr     <= next_ea;
      ea_used      <= (ea_sel != EA_NONE);
      dst_pre_dec  <= is_ctl_st && (fmt_w == FMT_N);
      dst_post_inc <= is_mac && (fmt_w == FMT_NM);
      src_post_inc <= (is_ctl_ld && (fmt_w == FMT_M)) || (is_mac && (fmt_w == FMT_NM));
      mac_target   <= is_mac && (fmt_w == FMT_NM);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_pc_short_ea: assert property (
    is_cbr |=> eff_addr == $past(pc) + {{23{$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0})
    else $error("short pc branch address wrong");
  a_pc_long_ea: assert property (
    is_jump |=> ea_used && eff_addr == $past(pc) + {{19{$past(instr_word[11])}}, $past(instr_word[11:0]), 1'b0})
    else $error("long pc branch address wrong");
  a_pc_reg_ea: assert property (
    is_jrel |=> eff_addr == $past(pc) + $past(gr_data) && src_reg == $past(instr_word[11:8]))
    else $error("pc plus register address wrong");
  a_imm_zero_ext: assert property (
    (fmt_w == FMT_I && is_logic_i) |=> imm_val == {24'h000000, $past(instr_word[7:0])})
    else $error("logic immediate not zero-extended");
  a_imm_sign_ext: assert property (
    (fmt_w == FMT_NI) |=> imm_val == {{24{$past(instr_word[7])}}, $past(instr_word[7:0])})
    else $error("immediate not sign-extended");
  a_trap_scale: assert property (
    is_trap |=> imm_used && imm_val == {22'h0, $past(instr_word[7:0]), 2'b00})
    else $error("trap offset wrong");
  a_zero_fmt: assert property (
    (fmt_w == FMT_ZERO) |=> !dst_used && !src_used && !imm_used && !disp_used && !ea_used)
    else $error("operand-less word produced a field");
  a_mac_ptrs: assert property (
    is_mac |=> mac_target && src_post_inc && dst_post_inc && src_reg == $past(instr_word[7:4]))
    else $error("mac pointers not post-incremented");
  a_gbase_scale: assert property (
    (fmt_w == FMT_D && is_gb_xfer && instr_word[9:8] == 2'b10) |=>
      eff_addr == $past(gbase_data) + {22'h0, $past(instr_word[7:0]), 2'b00})
    else $error("global base displacement wrong");
  a_nmd_fields: assert property (
    (fmt_w == FMT_NMD) |=> dst_reg == $past(instr_word[11:8]) && disp_val[5:2] == $past(instr_word[3:0]))
    else $error("three-field format decoded wrong");
  a_valid_timing: assert property (
    instr_valid |=> dec_valid ##1 (dec_valid == $past(instr_valid)))
    else $error("decode result not timed to the word");

  c_short_branch: cover property (instr_valid && is_cbr ##1 dec_valid);
  c_trap:         cover property (instr_valid && is_trap ##1 dec_valid);
  c_mac:          cover property (instr_valid && is_mac ##1 mac_target);
  c_gbase_byte:   cover property (instr_valid && is_logic_b ##1 ea_used);

endmodule

// ==== verilog/odc_ext.sv ====
// field extender: zero or sign extension and scaling
`timescale 1ns/1ps
module odc_ext
  import odc_pkg::*;
(
  input  wire logic [11:0]            field,
  input  odc_pkg::odc_len_t           len,
  input  wire logic                   sign_en,
  input  odc_pkg::odc_scale_t         scale,
  output logic [odc_pkg::ODC_XLEN-1:0] value
);

  logic        msb;
  logic        fill;
  logic [31:0] ext;

  assign msb  = (len == LEN12) ? field[11] : (len == LEN8) ? field[7] : field[3];
  assign fill = sign_en & msb;
  assign ext  = (len == LEN12) ? {{20{fill}}, field} :
                (len == LEN8)  ? {{24{fill}}, field[7:0]} :
                                 {{28{fill}}, field[3:0]};
  // scaling drops the top bits on purpose; the address wraps like the pc
  assign value = (scale == SC4) ? {ext[29:0], 2'b00} :
                 (scale == SC2) ? {ext[30:0], 1'b0} : ext;

endmodule
